//--- src/pmx_top.sv
// Purpose: Port direction, control-line and memory expansion multiplexer
// Assumes: Classic Wishbone register access, one clock, synchronous reset
// Notes: Every pin output and enable is registered, one cycle after its cause
//
// How it works
// - Ports A, B, C and F each have a per-line direction register.
// - Port D has one direction bit that turns all eight lines at once.
// - All eight analog lines are passed on to the converter outputs.
// - Analog lines 4 to 7 are also synchronised digital inputs whose falls raise flags.
// - Each port C line can be handed to a peripheral control line by its function bit.
// - The mode register offers single-chip plus four expansion modes.
// - In every expansion mode port D carries multiplexed low address and data.
// - The 4K mode takes port F lines 0 to 3 for address, leaving 4 to 7 as I/O.
// - The 16K mode takes port F lines 0 to 5 for address, leaving 6 and 7 as I/O.
// - The 60K mode takes all eight port F lines for address.
// - Port F address lines carry the high byte of the external address.
//
// The implementer's own choices: register access over Wishbone and the register addresses.

`timescale 1ns/1ns
`default_nettype none

module pmx_top (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [pmx_pkg::PMX_ADR_W-1:0] wb_adr_in,
    input wire logic [pmx_pkg::PMX_SEL_W-1:0] wb_sel_in,
    input wire logic [pmx_pkg::PMX_DAT_W-1:0] wb_dat_in,
    output logic [pmx_pkg::PMX_DAT_W-1:0] wb_dat_out,
    output logic wb_ack_out,
    output logic irq_out,
    // General ports
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe_out,
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe_out,
    input wire logic [7:0] pc_in,
    output logic [7:0] pc_out,
    output logic [7:0] pc_oe_out,
    input wire logic [7:0] pd_in,
    output logic [7:0] pd_out,
    output logic [7:0] pd_oe_out,
    input wire logic [7:0] pf_in,
    output logic [7:0] pf_out,
    output logic [7:0] pf_oe_out,
    // Peripheral control lines on port C
    input wire logic [7:0] ctrl_drive_in,
    input wire logic [7:0] ctrl_oe_in,
    output logic [7:0] ctrl_level_out,
    // Analog lines
    input wire logic [7:0] analog_in_line_in,
    output logic [7:0] adc_line_out,
    // External bus from the core
    input wire logic xbus_active_in,
    input wire logic xbus_addr_phase_in,
    input wire logic xbus_write_in,
    input wire logic [15:0] xbus_addr_in,
    input wire logic [7:0] xbus_wdata_in,
    output logic [7:0] xbus_rdata_out
);
    import pmx_pkg::*;

    // ****************************************************************
    // Storage
    // ****************************************************************
    pmx_mode_e mode;
    logic [7:0] pa_dir, pa_reg, pb_dir, pb_reg, pc_dir, pc_reg, pc_func;
    logic pd_dir;
    logic [7:0] pd_reg, pf_dir, pf_reg;
    logic [3:0] irq_stat, irq_en;
    logic [7:0] rd_byte;
    logic [7:0] f_addr_mask, pd_oe_next, pd_out_next, pf_oe_next, pf_out_next;
    logic [7:0] pc_oe_next, pc_out_next;
    logic [3:0] next_irq_stat, clr_bits;
    logic bus_req, wr_en, expanded, pd_drive;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    pmx_sync_if #(.W(40)) port_sif ();
    pmx_sync_if #(.W(PMX_ADIG_W)) adig_sif ();

    assign port_sif.raw = {pf_in, pd_in, pc_in, pb_in, pa_in};
    assign adig_sif.raw = analog_in_line_in[7:4];

    pmx_pin_sync #(.W(40)) u_port_sync (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .sif(port_sif)
    );

    pmx_pin_sync #(.W(PMX_ADIG_W)) u_adig_sync (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .sif(adig_sif)
    );

    // ****************************************************************
    // Bus decode and read selection
    // ****************************************************************
    assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr_en = bus_req && wb_we_in && wb_sel_in[0];
    assign clr_bits = (wr_en && wb_adr_in == PMX_OFS_IRQ_CLR) ? wb_dat_in[3:0] : PMX_RST_NIB;
    assign rd_byte =
        (wb_adr_in == PMX_OFS_MODE) ? {5'h00, mode} :
        (wb_adr_in == PMX_OFS_PA_DIR) ? pa_dir :
        (wb_adr_in == PMX_OFS_PA_OUT) ? pa_reg :
        (wb_adr_in == PMX_OFS_PB_DIR) ? pb_dir :
        (wb_adr_in == PMX_OFS_PB_OUT) ? pb_reg :
        (wb_adr_in == PMX_OFS_PC_DIR) ? pc_dir :
        (wb_adr_in == PMX_OFS_PC_OUT) ? pc_reg :
        (wb_adr_in == PMX_OFS_PC_FUNC) ? pc_func :
        (wb_adr_in == PMX_OFS_PD_DIR) ? {7'h00, pd_dir} :
        (wb_adr_in == PMX_OFS_PD_OUT) ? pd_reg :
        (wb_adr_in == PMX_OFS_PF_DIR) ? pf_dir :
        (wb_adr_in == PMX_OFS_PF_OUT) ? pf_reg :
        (wb_adr_in == PMX_OFS_PA_PIN) ? port_sif.level[7:0] :
        (wb_adr_in == PMX_OFS_PB_PIN) ? port_sif.level[15:8] :
        (wb_adr_in == PMX_OFS_PC_PIN) ? port_sif.level[23:16] :
        (wb_adr_in == PMX_OFS_PD_PIN) ? port_sif.level[31:24] :
        (wb_adr_in == PMX_OFS_PF_PIN) ? port_sif.level[39:32] :
        (wb_adr_in == PMX_OFS_ADIG_PIN) ? {4'h0, adig_sif.level} :
        (wb_adr_in == PMX_OFS_IRQ_STAT) ? {4'h0, irq_stat} :
        (wb_adr_in == PMX_OFS_IRQ_EN) ? {4'h0, irq_en} :
        PMX_RST_BYTE;

    // ****************************************************************
    // Pin selection
    // ****************************************************************
    // Port F lines claimed by the high address in the current mode
    assign f_addr_mask = (mode == PMX_EXP_4K) ? PMX_FMASK_4K :
                         (mode == PMX_EXP_16K) ? PMX_FMASK_16K :
                         (mode == PMX_EXP_60K) ? PMX_FMASK_60K :
                         PMX_RST_BYTE;
    assign pf_oe_next = f_addr_mask | (pf_dir & ~f_addr_mask);
    assign pf_out_next = (f_addr_mask & xbus_addr_in[15:8]) | (pf_reg & ~f_addr_mask);

    // Port D drives address, write data or nothing while expanded
    assign expanded = (mode != PMX_SINGLE);
    assign pd_drive = expanded ?
        (xbus_active_in && (xbus_addr_phase_in || xbus_write_in)) : pd_dir;
    assign pd_oe_next = pd_drive ? PMX_ALL_ONES : PMX_RST_BYTE;
    assign pd_out_next = !expanded ? pd_reg :
        (xbus_addr_phase_in ? xbus_addr_in[7:0] : xbus_wdata_in);

    // Port C lines follow the peripheral where handed over
    assign pc_oe_next = (pc_func & ctrl_oe_in) | (~pc_func & pc_dir);
    assign pc_out_next = (pc_func & ctrl_drive_in) | (~pc_func & pc_reg);

    // Flags set by falls win over a clear in the same cycle
    assign next_irq_stat = (irq_stat & ~clr_bits) | adig_sif.fall;

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Software-written configuration; unknown mode codes are ignored
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            mode <= PMX_SINGLE;
            pa_dir <= PMX_RST_BYTE;
            pb_dir <= PMX_RST_BYTE;
            pc_dir <= PMX_RST_BYTE;
            pd_dir <= 1'b0;
            pf_dir <= PMX_RST_BYTE;
            pc_func <= PMX_RST_BYTE;
            pa_reg <= PMX_RST_BYTE;
            pb_reg <= PMX_RST_BYTE;
            pc_reg <= PMX_RST_BYTE;
            pd_reg <= PMX_RST_BYTE;
            pf_reg <= PMX_RST_BYTE;
            irq_en <= PMX_RST_NIB;
        end else if (ce_in && wr_en) begin
            case (wb_adr_in)
                PMX_OFS_MODE: begin
                    if (wb_dat_in[2:0] <= 3'h4) begin
                        mode <= pmx_mode_e'(wb_dat_in[2:0]);
                    end
                end
                PMX_OFS_PA_DIR: pa_dir <= wb_dat_in[7:0];
                PMX_OFS_PA_OUT: pa_reg <= wb_dat_in[7:0];
                PMX_OFS_PB_DIR: pb_dir <= wb_dat_in[7:0];
                PMX_OFS_PB_OUT: pb_reg <= wb_dat_in[7:0];
                PMX_OFS_PC_DIR: pc_dir <= wb_dat_in[7:0];
                PMX_OFS_PC_OUT: pc_reg <= wb_dat_in[7:0];
                PMX_OFS_PC_FUNC: pc_func <= wb_dat_in[7:0];
                PMX_OFS_PD_DIR: pd_dir <= wb_dat_in[0];
                PMX_OFS_PD_OUT: pd_reg <= wb_dat_in[7:0];
                PMX_OFS_PF_DIR: pf_dir <= wb_dat_in[7:0];
                PMX_OFS_PF_OUT: pf_reg <= wb_dat_in[7:0];
                PMX_OFS_IRQ_EN: irq_en <= wb_dat_in[3:0];
                default: begin
                end
            endcase
        end
    end

    // Bus answer: one-cycle ack, read data captured with it
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
        end else if (ce_in) begin
            wb_ack_out <= bus_req;
            wb_dat_out <= {24'h000000, rd_byte};
        end
    end

    // Sticky falling-edge flags and the level interrupt
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            irq_stat <= PMX_RST_NIB;
            irq_out <= 1'b0;
        end else if (ce_in) begin
            irq_stat <= next_irq_stat;
            irq_out <= |(irq_stat & irq_en);
        end
    end

    // ****************************************************************
    // Registered pin drivers
    // ****************************************************************
    // Every pin output and enable leaves a flip-flop
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            pa_out <= PMX_RST_BYTE;
            pa_oe_out <= PMX_RST_BYTE;
            pb_out <= PMX_RST_BYTE;
            pb_oe_out <= PMX_RST_BYTE;
            pc_out <= PMX_RST_BYTE;
            pc_oe_out <= PMX_RST_BYTE;
            pd_out <= PMX_RST_BYTE;
            pd_oe_out <= PMX_RST_BYTE;
            pf_out <= PMX_RST_BYTE;
            pf_oe_out <= PMX_RST_BYTE;
            ctrl_level_out <= PMX_RST_BYTE;
            adc_line_out <= PMX_RST_BYTE;
            xbus_rdata_out <= PMX_RST_BYTE;
        end else if (ce_in) begin
            pa_out <= pa_reg;
            pa_oe_out <= pa_dir;
            pb_out <= pb_reg;
            pb_oe_out <= pb_dir;
            pc_out <= pc_out_next;
            pc_oe_out <= pc_oe_next;
            pd_out <= pd_out_next;
            pd_oe_out <= pd_oe_next;
            pf_out <= pf_out_next;
            pf_oe_out <= pf_oe_next;
            ctrl_level_out <= port_sif.level[23:16];
            adc_line_out <= analog_in_line_in;
            xbus_rdata_out <= port_sif.level[31:24];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_port_a_dir: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        ce_in |=> pa_oe_out == $past(pa_dir))
        else $error("port A enable does not follow its direction register");

    a_port_d_byte: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        pd_oe_out == 8'h00 || pd_oe_out == 8'hff)
        else $error("port D direction split within the byte");

    a_adc_route: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        ce_in |=> adc_line_out == $past(analog_in_line_in))
        else $error("analog line not passed to converter");

    a_fall_sets_flag: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && |adig_sif.fall)
            |=> (irq_stat & $past(adig_sif.fall)) == $past(adig_sif.fall))
        else $error("falling edge lost its flag");

    a_pc_ctrl_line: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && pc_func[2]) |=> pc_out[2] == $past(ctrl_drive_in[2])
            && pc_oe_out[2] == $past(ctrl_oe_in[2]))
        else $error("port C line not handed to its control line");

    a_mode_legal: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        mode inside {PMX_SINGLE, PMX_EXP_256, PMX_EXP_4K, PMX_EXP_16K, PMX_EXP_60K})
        else $error("mode register holds an unknown mode");

    a_pd_addr_phase: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && mode != PMX_SINGLE && xbus_active_in && xbus_addr_phase_in)
            |=> pd_oe_out == 8'hff && pd_out == $past(xbus_addr_in[7:0]))
        else $error("port D missing low address in expansion");

    a_pf_256_io: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && mode == PMX_EXP_256) |=> pf_oe_out == $past(pf_dir))
        else $error("port F not plain I/O in 256-byte mode");

    a_pf_4k_addr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && mode == PMX_EXP_4K) |=> pf_oe_out[3:0] == 4'hf
            && pf_out[3:0] == $past(xbus_addr_in[11:8])
            && pf_oe_out[7:4] == $past(pf_dir[7:4]))
        else $error("4K mode port F split wrong");

    a_pf_16k_addr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && mode == PMX_EXP_16K) |=> pf_oe_out[5:0] == 6'h3f
            && pf_out[5:0] == $past(xbus_addr_in[13:8])
            && pf_oe_out[7:6] == $past(pf_dir[7:6]))
        else $error("16K mode port F split wrong");

    a_pf_60k_addr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && mode == PMX_EXP_60K) |=> pf_oe_out == 8'hff
            && pf_out == $past(xbus_addr_in[15:8]))
        else $error("60K mode port F not all address");

    a_reset_inputs: assert property (@(posedge mclk_in)
        !rstn_in |=> mode == PMX_SINGLE && pa_oe_out == 8'h00 && pf_oe_out == 8'h00
            && pd_oe_out == 8'h00 && pc_func == 8'h00)
        else $error("reset did not return single-chip all-input state");
endmodule

`default_nettype wire

//--- src/pmx_pkg.sv
// Purpose: Shared constants and types for the port and memory expansion multiplexer
// Assumes: Classic Wishbone slave with 8-bit register data in the low byte lane
// Notes: Offsets are byte addresses of aligned 32-bit words

// ****************************************************************
// Package
// ****************************************************************
package pmx_pkg;
    // Expansion modes, single-chip first so that reset selects it
    typedef enum logic [2:0] {
        PMX_SINGLE,
        PMX_EXP_256,
        PMX_EXP_4K,
        PMX_EXP_16K,
        PMX_EXP_60K
    } pmx_mode_e;

    localparam int PMX_PORT_W = 8;
    localparam int PMX_ALINE_W = 8;
    localparam int PMX_ADIG_W = 4;
    localparam int PMX_ADR_W = 8;
    localparam int PMX_DAT_W = 32;
    localparam int PMX_SEL_W = 4;

    // Register offsets
    localparam logic [7:0] PMX_OFS_MODE = 8'h00;
    localparam logic [7:0] PMX_OFS_PA_DIR = 8'h04;
    localparam logic [7:0] PMX_OFS_PA_OUT = 8'h08;
    localparam logic [7:0] PMX_OFS_PB_DIR = 8'h0c;
    localparam logic [7:0] PMX_OFS_PB_OUT = 8'h10;
    localparam logic [7:0] PMX_OFS_PC_DIR = 8'h14;
    localparam logic [7:0] PMX_OFS_PC_OUT = 8'h18;
    localparam logic [7:0] PMX_OFS_PC_FUNC = 8'h1c;
    localparam logic [7:0] PMX_OFS_PD_DIR = 8'h20;
    localparam logic [7:0] PMX_OFS_PD_OUT = 8'h24;
    localparam logic [7:0] PMX_OFS_PF_DIR = 8'h28;
    localparam logic [7:0] PMX_OFS_PF_OUT = 8'h2c;
    localparam logic [7:0] PMX_OFS_PA_PIN = 8'h30;
    localparam logic [7:0] PMX_OFS_PB_PIN = 8'h34;
    localparam logic [7:0] PMX_OFS_PC_PIN = 8'h38;
    localparam logic [7:0] PMX_OFS_PD_PIN = 8'h3c;
    localparam logic [7:0] PMX_OFS_PF_PIN = 8'h40;
    localparam logic [7:0] PMX_OFS_ADIG_PIN = 8'h44;
    localparam logic [7:0] PMX_OFS_IRQ_STAT = 8'h48;
    localparam logic [7:0] PMX_OFS_IRQ_CLR = 8'h4c;
    localparam logic [7:0] PMX_OFS_IRQ_EN = 8'h50;

    // Values after reset, and the all-ones port D enable
    localparam logic [7:0] PMX_RST_BYTE = 8'h00;
    localparam logic [3:0] PMX_RST_NIB = 4'h0;
    localparam logic [7:0] PMX_ALL_ONES = 8'hff;

    // Port F lines taken for the high address in each wide mode
    localparam logic [7:0] PMX_FMASK_4K = 8'h0f;
    localparam logic [7:0] PMX_FMASK_16K = 8'h3f;
    localparam logic [7:0] PMX_FMASK_60K = 8'hff;
endpackage

//--- src/pmx_sync_if.sv
// Purpose: Carrier between the multiplexer and its pin synchroniser
// Assumes: One clock domain
// Notes: Raw pin levels in, filtered levels and falling-edge pulses out

`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Interface
// ****************************************************************
interface pmx_sync_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    logic [W-1:0] fall;
    modport sync (input raw, output level, output fall);
    modport user (output raw, input level, input fall);
endinterface

`default_nettype wire

//--- src/pmx_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter and fall detect
// Assumes: Pins are asynchronous to mclk_in
// Notes: Stage one is read only by stage two

`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Pin synchroniser
// ****************************************************************
module pmx_pin_sync #(
    parameter int W = 8
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    pmx_sync_if.sync sif
);
    import pmx_pkg::*;

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] level;
    logic [W-1:0] fall;
    logic [W-1:0] next_level;

    // Refuse a width that leaves no lines to synchronise
    if (W < 1) begin : g_bad_width
        $error("pmx_pin_sync width must be at least one");
    end

    // A bit moves only once stages two and three agree
    assign next_level = (stage2 & stage3) | (level & (stage2 | stage3));

    // Synchroniser chain, filtered level and one-cycle fall pulse
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
            fall <= '0;
        end else if (ce_in) begin
            stage1 <= sif.raw;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
            fall <= level & ~next_level;
        end
    end

    assign sif.level = level;
    assign sif.fall = fall;
endmodule

`default_nettype wire

//--- test/pmx_far_mem.sv
// Purpose: External memory on the multiplexed low address/data bus
// Assumes: Address is latched while ale_in is high
// Notes: A released bus toggles every cycle so a stale value never passes

`timescale 1ns/1ns
`default_nettype none

// ********************
// External memory
// ********************
module pmx_far_mem (
    input wire logic mclk_in,
    input wire logic ale_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] pd_in,
    output logic [7:0] pd_out
);
    logic [7:0] mem [256];
    logic [7:0] adr;
    initial pd_out = 8'h00;
    // Latch the low address, store writes, answer reads or release the bus
    always @(posedge mclk_in) begin
        if (ale_in) adr <= pd_in;
        if (wr_in) mem[adr] <= pd_in;
        pd_out <= rd_in ? mem[adr] : ~pd_out;
    end
endmodule

`default_nettype wire

//--- test/port_memory_expansion_mux_bench.sv
// Purpose: Self-checking bench for the port and memory expansion multiplexer
// Assumes: Ack comes one cycle after a request is taken
// Notes: Pins are looked at on the falling edge, after updates land

`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end

module port_memory_expansion_mux_bench;
    import pmx_pkg::*;
    typedef struct packed {
        logic [7:0] mode; logic [7:0] pfoe; logic [7:0] pdoe; logic [7:0] pfout; logic [7:0] pdout;
    } pmx_row_s;
    // Mode code, then port F enable, port D enable, port F and port D drive
    localparam pmx_row_s ROWS [6] = '{'{8'h00, 8'h80, 8'h00, 8'h00, 8'h00},
        '{8'h01, 8'h80, 8'hff, 8'h00, 8'ha5}, '{8'h02, 8'h8f, 8'hff, 8'h03, 8'ha5},
        '{8'h03, 8'hbf, 8'hff, 8'h03, 8'ha5}, '{8'h04, 8'hff, 8'hff, 8'hc3, 8'ha5},
        '{8'h05, 8'hff, 8'hff, 8'hc3, 8'ha5}};
    localparam logic [7:0] DIR_OFS [4] = '{8'h04, 8'h0c, 8'h14, 8'h28};
    localparam logic [7:0] PIN_OFS [4] = '{8'h30, 8'h34, 8'h38, 8'h40};
    logic mclk_in = 1'b0, rstn_in = 1'b0, ce_in = 1'b1;
    logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, wb_ack_out, irq_out;
    logic [7:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'h1;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
    logic [7:0] pa_out, pa_oe_out, pb_out, pb_oe_out, pc_out, pc_oe_out, pd_out, pd_oe_out;
    logic [7:0] pf_out, pf_oe_out, ctrl_level_out, adc_line_out, xbus_rdata_out, pd_in, mem_drive;
    logic [7:0] pins [4] = '{8'h96, 8'h5a, 8'h3c, 8'hc9};
    logic [7:0] ctrl_drive_in = 8'ha5, ctrl_oe_in = 8'h33, analog_in_line_in = 8'hff;
    logic [7:0] xbus_wdata_in = 8'h00;
    logic xbus_active_in = 1'b0, xbus_addr_phase_in = 1'b0, xbus_write_in = 1'b0;
    logic [15:0] xbus_addr_in = 16'hc3a5, pv;
    int errors = 0, samples_checked = 0;

    // Wire level of port D from the multiplexer's enable; the memory drives the rest
    assign pd_in = (pd_oe_out & pd_out) | (~pd_oe_out & mem_drive);

    pmx_top u_pmx_top (.mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(ce_in),
        .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .irq_out(irq_out),
        .pa_in(pins[0]), .pa_out(pa_out), .pa_oe_out(pa_oe_out),
        .pb_in(pins[1]), .pb_out(pb_out), .pb_oe_out(pb_oe_out),
        .pc_in(pins[2]), .pc_out(pc_out), .pc_oe_out(pc_oe_out),
        .pd_in(pd_in), .pd_out(pd_out), .pd_oe_out(pd_oe_out),
        .pf_in(pins[3]), .pf_out(pf_out), .pf_oe_out(pf_oe_out),
        .ctrl_drive_in(ctrl_drive_in), .ctrl_oe_in(ctrl_oe_in), .ctrl_level_out(ctrl_level_out),
        .analog_in_line_in(analog_in_line_in), .adc_line_out(adc_line_out),
        .xbus_active_in(xbus_active_in), .xbus_addr_phase_in(xbus_addr_phase_in),
        .xbus_write_in(xbus_write_in), .xbus_addr_in(xbus_addr_in),
        .xbus_wdata_in(xbus_wdata_in), .xbus_rdata_out(xbus_rdata_out));

    pmx_far_mem u_pmx_far_mem (.mclk_in(mclk_in), .ale_in(xbus_active_in & xbus_addr_phase_in),
        .rd_in(xbus_active_in & ~xbus_write_in & ~xbus_addr_phase_in),
        .wr_in(xbus_active_in & xbus_write_in & ~xbus_addr_phase_in),
        .pd_in(pd_in), .pd_out(mem_drive));

    // ********************
    // Tasks
    // ********************
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Step n rising edges, then settle on the falling edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask

    // One classic cycle, held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] d);
        int n = 0;
        @(posedge mclk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= adr;
        wb_dat_in <= {24'h0, d};
        do begin
            @(posedge mclk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 16);
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in <= 1'b0;
        if (wb_ack_out !== 1'b1) begin
            errors++;
            complete_run();
        end
    endtask

    task automatic rchk(input logic [7:0] adr, input logic [31:0] e, input string nm);
        wb_xfer(1'b0, adr, 8'h00);
        `CHK(nm, e, rd)
    endtask

    function automatic logic [15:0] port_of(input int i);
        case (i)
            0: return {pa_oe_out, pa_out};
            1: return {pb_oe_out, pb_out};
            2: return {pc_oe_out, pc_out};
            default: return {pf_oe_out, pf_out};
        endcase
    endfunction

    // ********************
    // Clock, watchdog and main sequence
    // ********************
    initial forever #25 mclk_in = ~mclk_in;
    initial begin
        repeat (20000) @(posedge mclk_in);
        errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(negedge mclk_in);
        `CHK("oe", 8'h00, pa_oe_out | pb_oe_out | pc_oe_out | pd_oe_out | pf_oe_out)
        rchk(PMX_OFS_MODE, 32'h0, "mode");
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            wb_xfer(1'b1, DIR_OFS[i], 8'ha5 ^ 8'(i));
            wb_xfer(1'b1, DIR_OFS[i] + 8'h04, 8'h3c);
            tick(2);
            pv = port_of(i);
            `CHK("oe", 8'ha5 ^ 8'(i), pv[15:8])
            `CHK("out", 8'h3c & (8'ha5 ^ 8'(i)), pv[7:0] & pv[15:8])
            rchk(DIR_OFS[i], {24'h0, 8'ha5 ^ 8'(i)}, "dir");
            rchk(PIN_OFS[i], {24'h0, pins[i]}, "pin");
        end
        $display("Test line directions done");
        wb_xfer(1'b1, PMX_OFS_PD_DIR, 8'h01);
        tick(2);
        `CHK("pd_oe", 8'hff, pd_oe_out)
        wb_xfer(1'b1, PMX_OFS_PD_DIR, 8'hfe);
        tick(2);
        `CHK("pd_oe", 8'h00, pd_oe_out)
        wb_xfer(1'b1, PMX_OFS_PC_DIR, 8'hf0);
        wb_xfer(1'b1, PMX_OFS_PC_OUT, 8'hff);
        wb_xfer(1'b1, PMX_OFS_PC_FUNC, 8'h0f);
        tick(2);
        `CHK("pc_oe", 8'hf3, pc_oe_out)
        `CHK("pc_out", 8'hf1, pc_out & pc_oe_out)
        `CHK("ctrl", pins[2], ctrl_level_out)
        $display("Test byte direction and control lines done");
        wb_xfer(1'b1, PMX_OFS_IRQ_EN, 8'h0f);
        `CHK("adc", 8'hff, adc_line_out)
        analog_in_line_in <= 8'hdf;
        tick(8);
        `CHK("irq", 1'b1, irq_out)
        rchk(PMX_OFS_IRQ_STAT, 32'h2, "stat");
        wb_xfer(1'b1, PMX_OFS_IRQ_CLR, 8'h02);
        tick(2);
        `CHK("irq", 1'b0, irq_out)
        rchk(PMX_OFS_IRQ_STAT, 32'h0, "stat");
        wb_xfer(1'b1, PMX_OFS_IRQ_EN, 8'h00);
        analog_in_line_in <= 8'h9f;
        tick(8);
        rchk(PMX_OFS_IRQ_STAT, 32'h4, "stat");
        `CHK("irq", 1'b0, irq_out)
        `CHK("adc", 8'h9f, adc_line_out)
        rchk(PMX_OFS_ADIG_PIN, 32'h9, "adig");
        rchk(8'hfc, 32'h0, "unmapped");
        $display("Test analog lines done");
        wb_xfer(1'b1, PMX_OFS_PF_DIR, 8'h80);
        wb_xfer(1'b1, PMX_OFS_PF_OUT, 8'h00);
        xbus_active_in <= 1'b1;
        xbus_addr_phase_in <= 1'b1;
        foreach (ROWS[i]) begin
            wb_xfer(1'b1, PMX_OFS_MODE, ROWS[i].mode);
            tick(2);
            `CHK("pd_oe", ROWS[i].pdoe, pd_oe_out)
            `CHK("pd_out", ROWS[i].pdout, pd_out)
            `CHK("pf_oe", ROWS[i].pfoe, pf_oe_out)
            `CHK("pf_out", ROWS[i].pfout, pf_out)
        end
        $display("Test expansion modes done");
        wb_xfer(1'b1, PMX_OFS_MODE, 8'h02);
        xbus_addr_in <= 16'h0312;
        tick(2);
        @(posedge mclk_in);
        xbus_addr_phase_in <= 1'b0;
        xbus_write_in <= 1'b1;
        xbus_wdata_in <= 8'h5e;
        tick(2);
        `CHK("pd_out", 8'h5e, pd_out)
        `CHK("pf_out", 8'h03, pf_out)
        @(posedge mclk_in);
        xbus_addr_phase_in <= 1'b1;
        xbus_write_in <= 1'b0;
        tick(2);
        @(posedge mclk_in);
        xbus_addr_phase_in <= 1'b0;
        tick(8);
        `CHK("pd_oe", 8'h00, pd_oe_out)
        `CHK("rdata", 8'h5e, xbus_rdata_out)
        $display("Test external transfer done");
        @(posedge mclk_in);
        ce_in <= 1'b0;
        analog_in_line_in <= 8'h0f;
        tick(3);
        `CHK("ce_hold", 8'h9f, adc_line_out)
        @(posedge mclk_in);
        ce_in <= 1'b1;
        rstn_in <= 1'b0;
        xbus_addr_phase_in <= 1'b1;
        tick(2);
        @(posedge mclk_in);
        rstn_in <= 1'b1;
        tick(1);
        `CHK("oe", 8'h00, pd_oe_out | pf_oe_out | pa_oe_out)
        rchk(PMX_OFS_MODE, 32'h0, "mode");
        $display("Test second reset done");
        complete_run();
    end
endmodule

`default_nettype wire
